// ==== design/osbt_pkg.sv ====
// osbt_pkg: constants and types for the sync and blanking timing block.
// assumes: one 200 MHz clock, pixel rate made by an enable divider.
package osbt_pkg;
  // ==========================================================
  // register bus
  localparam int          AXI_AW      = 18;
  localparam int          AXI_DW      = 32;
  localparam int          IDX_W       = 16;
  // printed offsets are register indices; byte address is index times four
  localparam logic [15:0] IDX_HSYNC   = 16'h87FC;
  localparam logic [15:0] IDX_HALF    = 16'h87FD;
  localparam logic [15:0] IDX_CFG     = 16'h87FF;
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [23:0] RD_PAD      = 24'h000000;
  // ==========================================================
  // register fields
  localparam int          DLY_W       = 7;
  localparam logic [6:0]  DLY_MAX     = 7'h3F;
  localparam int          CFG_MODE_B  = 7;
  localparam int          CFG_SEL_LO  = 4;
  localparam int          SEL_W       = 3;
  localparam logic [2:0]  BLANK_OFF   = 3'h0;
  localparam logic [2:0]  BLANK_EARLY = 3'h1;
  localparam logic [2:0]  BLANK_ALIGN = 3'h2;
  localparam logic [2:0]  BLANK_LATE  = 3'h4;
  localparam logic [2:0]  BLANK_ALL   = 3'h7;
  // ==========================================================
  // timing
  localparam int          CLK_MHZ     = 200;
  localparam int          PIX_DIV     = 4;
  localparam int          PDIV_W      = 2;
  localparam logic [1:0]  PDIV_LAST   = 2'(PIX_DIV - 1);
  localparam int          CHAR_PIX    = 12;
  localparam int          HALF_STEP   = 12;
  localparam int          CNT_W       = 11;
  localparam logic [10:0] CNT_ONE     = 11'h001;
  localparam int          PIN_N       = 2;
  localparam int          PIN_HSYNC   = 0;
  localparam int          PIN_HALF    = 1;
  // ==========================================================
  // types
  typedef enum logic [1:0] {SEL_NONE, SEL_HSYNC, SEL_HALF, SEL_CFG} osbt_sel_t;
  typedef struct packed {
    logic [2:0] rgb;        // pixel colour from the character path
    logic       blankReq;   // pixel is lit and needs fast blanking
    logic       underline;  // underline requested for this pixel
    logic       serialAttr; // serial attribute is being displayed
  } osbt_pix_t;
endpackage

// ==== design/osbt_delay_unit.sv ====
// osbt_delay_unit: delays a sync event by a count of pixel steps.
// assumes: trigger is a one-cycle pulse; pixEn is one cycle in PIX_DIV.
`timescale 1ns/100ps
module osbt_delay_unit #(
  parameter int STEP = osbt_pkg::CHAR_PIX
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  // event and delay
  input  wire logic                      pixEn,
  input  wire logic                      trigger,
  input  wire logic [osbt_pkg::DLY_W-1:0] delaySteps,
  // delayed pulse
  output logic                           pulseOut
);
  import osbt_pkg::*;
  // ==========================================================
  // counter
  logic             busy_r;
  logic [CNT_W-1:0] cnt_r;
  logic             busyNxt;
  logic [CNT_W-1:0] cntNxt;
  logic             pulseNxt;
  logic [CNT_W-1:0] loadCnt;
  logic             lastTick;
  // the delay is latched at the event, so a write only affects the next one
  assign loadCnt  = CNT_W'(delaySteps * STEP);
  assign lastTick = busy_r && pixEn && (cnt_r == CNT_ONE);
  assign pulseNxt = trigger ? (delaySteps == '0) : lastTick;
  assign busyNxt  = trigger ? (delaySteps != '0) : (busy_r && !lastTick);
  assign cntNxt   = trigger ? loadCnt : ((busy_r && pixEn) ? cnt_r - CNT_ONE : cnt_r);
  // a new event restarts the count rather than queueing behind it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_r   <= 1'b0;
      cnt_r    <= '0;
      pulseOut <= 1'b0;
    end else begin
      busy_r   <= busyNxt;
      cnt_r    <= cntNxt;
      pulseOut <= pulseNxt;
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_DLY_ZERO: assert property (trigger && delaySteps == '0 |=> pulseOut)
    else $error("zero delay did not pulse next cycle");
  AST_DLY_QUIET: assert property (trigger && delaySteps != '0 |=> !pulseOut [*8])
    else $error("pulse came before the programmed delay");
  AST_DLY_ONE: assert property (trigger && delaySteps == 7'h01 ##1 (!trigger) [*8]
      |-> ##[38:41] pulseOut)
    else $error("one step delay missed its window");
endmodule

// ==== design/osbt_fbl.sv ====
// osbt_fbl: pixel pipeline producing rgb and the fast blanking output.
// assumes: pixel data arrives once per pixEn from the character path.
`timescale 1ns/100ps
module osbt_fbl (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  // pixel stream
  input  wire logic                      pixEn,
  input  wire osbt_pkg::osbt_pix_t       pixIn,
  input  wire logic [osbt_pkg::SEL_W-1:0] blankSel,
  // video out
  output logic [2:0]                     rgbOut,
  output logic                           fastBlankingOut
);
  import osbt_pkg::*;
  // ==========================================================
  // pipeline: rgb leaves one pixel after entry, blanking taps around it
  logic [2:0] rgbHold_r;
  logic       reqD1_r;
  logic       reqD2_r;
  logic       blankNxt;
  // early, aligned and late terms are simply ORed, so adjacent taps widen the pulse
  assign blankNxt = (blankSel[0] && pixIn.blankReq)
                  | (blankSel[1] && reqD1_r)
                  | (blankSel[2] && reqD2_r);
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rgbHold_r       <= '0;
      rgbOut          <= '0;
      reqD1_r         <= 1'b0;
      reqD2_r         <= 1'b0;
      fastBlankingOut <= 1'b0;
    end else if (pixEn) begin
      rgbHold_r       <= pixIn.rgb;
      rgbOut          <= rgbHold_r;
      reqD1_r         <= pixIn.blankReq;
      reqD2_r         <= reqD1_r;
      fastBlankingOut <= blankNxt;
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_FBL_OFF: assert property ((blankSel == BLANK_OFF) [*5] |-> !fastBlankingOut)
    else $error("blanking active with all selects clear");
  AST_FBL_EARLY: assert property (pixEn && pixIn.blankReq && blankSel == BLANK_EARLY
      |=> fastBlankingOut)
    else $error("early blanking missing");
  AST_FBL_ALIGN: assert property (pixEn && pixIn.blankReq && blankSel == BLANK_ALIGN
      ##1 (blankSel == BLANK_ALIGN) [*4] |=> fastBlankingOut)
    else $error("aligned blanking missing");
  AST_FBL_LATE: assert property (pixEn && pixIn.blankReq && blankSel == BLANK_LATE
      ##1 (blankSel == BLANK_LATE) [*8] |=> fastBlankingOut)
    else $error("late blanking missing");
  COV_FBL_ALL: cover property (blankSel == BLANK_ALL && fastBlankingOut);
endmodule

// ==== design/osbt_top.sv ====
// osbt_top: sync delay, half-line delay, display mode and fast blanking
// timing, with the three byte registers behind an AXI4-Lite slave.
// assumes: sync pins are asynchronous; pixel stream is on clk_sys.
//
// Behaviour
// - internal horizontal sync is delayed by a 7-bit count of character periods, held at 63.
// - half-line pulse is delayed by a 7-bit count of twelve-pixel steps.
// - config bit 7 clear gives overlay mode, set gives caption mode.
// - in caption mode underline is suppressed while a serial attribute shows.
// - all blanking selects clear keeps fast blanking inactive.
// - only bit 4 set puts blanking one pixel before rgb.
// - only bit 5 set puts blanking aligned with rgb.
// - only bit 6 set puts blanking one pixel after rgb.
// - several select bits OR the early, aligned and late pulses together.
`timescale 1ns/100ps
module osbt_top (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  // axi4-lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [osbt_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  // axi4-lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [osbt_pkg::AXI_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // axi4-lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // axi4-lite read
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [osbt_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [osbt_pkg::AXI_DW-1:0]       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // sync pins
  input  wire logic                         hsyncIn,
  input  wire logic                         halfLineIn,
  // pixel stream
  input  wire osbt_pkg::osbt_pix_t          pixIn,
  output logic                              pixelTick,
  // timing and video outputs
  output logic                              hsyncDelayed,
  output logic                              halfLinePulse,
  output logic                              captionModeSelect,
  output logic [2:0]                        rgbOut,
  output logic                              underlineOut,
  output logic                              fastBlankingOut
);
  import osbt_pkg::*;

  // ==========================================================
  // register decode
  // one decoder serves both address channels so they cannot disagree
  function automatic osbt_sel_t regSel(input logic [AXI_AW-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[AXI_AW-1:2];
    if (idx == IDX_HSYNC) begin
      regSel = SEL_HSYNC;
    end else if (idx == IDX_HALF) begin
      regSel = SEL_HALF;
    end else if (idx == IDX_CFG) begin
      regSel = SEL_CFG;
    end else begin
      regSel = SEL_NONE;
    end
  endfunction

  // ==========================================================
  // write channel state
  logic                  awHeld_r;
  logic                  wHeld_r;
  logic [AXI_AW-1:0]     awAddr_r;
  logic [7:0]            wByte_r;
  logic                  wLane_r;
  logic                  awTake;
  logic                  wTake;
  logic                  wrFire;
  osbt_sel_t             wrSel;

  // each channel is taken on its own; the write fires once both are held
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign awTake        = s_axi_awvalid && s_axi_awready;
  assign wTake         = s_axi_wvalid && s_axi_wready;
  assign wrFire        = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wrSel         = regSel(awAddr_r);

  // address and data holding
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (awTake) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wHeld_r <= 1'b0;
      wByte_r <= REG_RST;
      wLane_r <= 1'b0;
    end else if (wTake) begin
      wHeld_r <= 1'b1;
      wByte_r <= s_axi_wdata[7:0];
      wLane_r <= s_axi_wstrb[0];
    end else if (wrFire) begin
      wHeld_r <= 1'b0;
    end
  end

  // write response; unmapped addresses are refused with slverr
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // registers
  logic [7:0] hsyncDelay_r;
  logic [7:0] halfAlign_r;
  logic [7:0] cfg_r;
  logic       wrEn;

  // only byte lane 0 carries register data; other lanes are ignored
  assign wrEn = wrFire && wLane_r;

  // all bits are stored as written, test and reserved bits included
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hsyncDelay_r <= REG_RST;
      halfAlign_r  <= REG_RST;
      cfg_r        <= REG_RST;
    end else if (wrEn) begin
      if (wrSel == SEL_HSYNC) hsyncDelay_r <= wByte_r;
      if (wrSel == SEL_HALF)  halfAlign_r  <= wByte_r;
      if (wrSel == SEL_CFG)   cfg_r        <= wByte_r;
    end
  end

  // ==========================================================
  // read channel
  osbt_sel_t  rdSel;
  logic [7:0] rdByte;

  assign s_axi_arready = !s_axi_rvalid;
  assign rdSel         = regSel(s_axi_araddr);
  assign rdByte        = (rdSel == SEL_HSYNC) ? hsyncDelay_r :
                         (rdSel == SEL_HALF)  ? halfAlign_r  :
                         (rdSel == SEL_CFG)   ? cfg_r        : REG_RST;

  // the answer is captured with the address and held until rready
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {RD_PAD, rdByte};
      s_axi_rresp  <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // pixel rate divider
  logic [PDIV_W-1:0] pixCnt_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pixCnt_r  <= '0;
      pixelTick <= 1'b0;
    end else begin
      pixCnt_r  <= (pixCnt_r == PDIV_LAST) ? '0 : pixCnt_r + 1'b1;
      pixelTick <= (pixCnt_r == PDIV_LAST);
    end
  end

  // ==========================================================
  // sync pin conditioning
  // a level counts only once the second and third stages agree, which
  // also rejects single-cycle glitches on the pins
  logic [PIN_N-1:0] pinIn;
  logic [PIN_N-1:0] pinMeta_r;
  logic [PIN_N-1:0] pinSync_r;
  logic [PIN_N-1:0] pinLast_r;
  logic [PIN_N-1:0] pinLvl_r;
  logic [PIN_N-1:0] pinRise;

  assign pinIn[PIN_HSYNC] = hsyncIn;
  assign pinIn[PIN_HALF]  = halfLineIn;

  genvar gi;
  for (gi = 0; gi < PIN_N; gi++) begin : g_pin
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        pinMeta_r[gi] <= 1'b0;
        pinSync_r[gi] <= 1'b0;
        pinLast_r[gi] <= 1'b0;
        pinLvl_r[gi]  <= 1'b0;
      end else begin
        pinMeta_r[gi] <= pinIn[gi];
        pinSync_r[gi] <= pinMeta_r[gi];
        pinLast_r[gi] <= pinSync_r[gi];
        if (pinSync_r[gi] == pinLast_r[gi]) pinLvl_r[gi] <= pinSync_r[gi];
      end
    end
    assign pinRise[gi] = (pinSync_r[gi] == pinLast_r[gi]) && pinSync_r[gi] && !pinLvl_r[gi];
  end

  // ==========================================================
  // sync delays
  logic [DLY_W-1:0] hsSteps;
  logic [DLY_W-1:0] halfSteps;

  // bit 7 is dropped; hsync values above the top of the range are held at it
  assign hsSteps   = (hsyncDelay_r[DLY_W-1:0] > DLY_MAX) ? DLY_MAX
                                                         : hsyncDelay_r[DLY_W-1:0];
  assign halfSteps = halfAlign_r[DLY_W-1:0];

  osbt_delay_unit #(
    .STEP       (CHAR_PIX)
  ) u_hsync_dly (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .pixEn      (pixelTick),
    .trigger    (pinRise[PIN_HSYNC]),
    .delaySteps (hsSteps),
    .pulseOut   (hsyncDelayed)
  );

  osbt_delay_unit #(
    .STEP       (HALF_STEP)
  ) u_half_dly (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .pixEn      (pixelTick),
    .trigger    (pinRise[PIN_HALF]),
    .delaySteps (halfSteps),
    .pulseOut   (halfLinePulse)
  );

  // ==========================================================
  // display mode and underline
  // the mode bit is a plain level; the test bits 2..0 drive nothing
  assign captionModeSelect = cfg_r[CFG_MODE_B];

  // underline rides the same pixel slot as rgb so both leave together
  logic ulineHold_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ulineHold_r  <= 1'b0;
      underlineOut <= 1'b0;
    end else if (pixelTick) begin
      ulineHold_r  <= pixIn.underline && !(captionModeSelect && pixIn.serialAttr);
      underlineOut <= ulineHold_r;
    end
  end

  // ==========================================================
  // fast blanking
  osbt_fbl u_fbl (
    .clk_sys         (clk_sys),
    .rstn            (rstn),
    .pixEn           (pixelTick),
    .pixIn           (pixIn),
    .blankSel        (cfg_r[CFG_SEL_LO +: SEL_W]),
    .rgbOut          (rgbOut),
    .fastBlankingOut (fastBlankingOut)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_HS_RANGE: assert property (hsSteps == (hsyncDelay_r[DLY_W-1] ? DLY_MAX
      : {1'b0, hsyncDelay_r[DLY_W-2:0]}))
    else $error("horizontal sync delay beyond range");
  AST_MODE_SET: assert property (wrEn && wrSel == SEL_CFG && wByte_r[CFG_MODE_B]
      |=> captionModeSelect)
    else $error("caption mode not selected after write");
  AST_MODE_CLR: assert property (wrEn && wrSel == SEL_CFG && !wByte_r[CFG_MODE_B]
      |=> !captionModeSelect)
    else $error("overlay mode not selected after write");
  AST_ULINE: assert property (pixelTick && captionModeSelect && pixIn.serialAttr
      ##1 (!pixelTick) [*3] ##1 pixelTick |=> !underlineOut [*4])
    else $error("underline shown under serial attribute in caption mode");
  AST_BRESP: assert property (wrFire |=> s_axi_bvalid)
    else $error("write response missing");

  COV_WRITE_CFG: cover property (wrEn && wrSel == SEL_CFG);
  COV_READ_ERR:  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  COV_HS_PULSE:  cover property (hsyncDelayed && hsSteps != '0);

endmodule

// ==== sim/osbt_tv_model.sv ====
// osbt_tv_model: video processor side, samples rgb, blanking, underline.
// assumes: block outputs stay steady for the whole pixel between ticks.
`timescale 1ns/100ps
module osbt_tv_model (
  // pixel timing
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       pixelTick,
  // video from the block
  input  wire logic [2:0] rgbOut,
  input  wire logic       fastBlankingOut,
  input  wire logic       underlineOut,
  // recent pixels, newest in bit 0
  output logic [7:0]      litHist,
  output logic [7:0]      fblHist,
  output logic [7:0]      ulHist
);
  // ==========================================================
  // sampling
  // one sample a pixel, so blanking a pixel off shows as a shifted bit
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      litHist <= 8'h00;
      fblHist <= 8'h00;
      ulHist  <= 8'h00;
    end else if (pixelTick) begin
      litHist <= {litHist[6:0], |rgbOut};
      fblHist <= {fblHist[6:0], fastBlankingOut};
      ulHist  <= {ulHist[6:0], underlineOut};
    end
  end
endmodule

// ==== sim/osd_sync_and_blanking_timing_test.sv ====
// osd_sync_and_blanking_timing_test: registers, sync delays, pixel path.
// assumes: osbt_top as handed over, 200 MHz clock, seed fixed.
`timescale 1ns/100ps
module osd_sync_and_blanking_timing_test;
  import osbt_pkg::*;
  // ==========================================================
  // signals
  localparam logic [17:0] A_HS = {IDX_HSYNC, 2'h0};
  localparam logic [17:0] A_HALF = {IDX_HALF, 2'h0};
  localparam logic [17:0] A_CFG = {IDX_CFG, 2'h0};
  localparam logic [17:0] A_NONE = {16'h87FE, 2'h0};
  logic clk_sys = 1'b0, rstn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic hsyncIn = 1'b0, halfLineIn = 1'b0;
  osbt_pix_t pixIn = '0;
  logic pixelTick, hsyncDelayed, halfLinePulse, captionModeSelect;
  logic underlineOut, fastBlankingOut;
  logic [2:0] rgbOut;
  logic [7:0] litHist, fblHist, ulHist;
  int miscompares = 0, checked = 0;
  // ==========================================================
  // block and video processor
  osbt_top dut (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .hsyncIn, .halfLineIn, .pixIn, .pixelTick, .hsyncDelayed,
    .halfLinePulse, .captionModeSelect, .rgbOut, .underlineOut, .fastBlankingOut);
  osbt_tv_model tv (.clk_sys, .rstn, .pixelTick, .rgbOut, .fastBlankingOut,
    .underlineOut, .litHist, .fblHist, .ulHist);
  // 5 ns period
  always #2.5 clk_sys = ~clk_sys;
  // ==========================================================
  // checking and verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic hang(input string what);
    $display("Error %s expected answer seen none", what);
    miscompares++;
    give_verdict();
  endtask
  // blanking history: early pixel older than rgb, late pixel newer
  function automatic logic [7:0] fbl_exp(input logic [2:0] s);
    return {3'h0, s[0], s[1], s[2], 2'h0};
  endfunction
  // ==========================================================
  // bus master; handshakes looked at 1 ns after the edge, acted on at the next
  task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      #1;
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang("bvalid");
    check("bresp", r, er);
  endtask
  task automatic axi_rd(input logic [17:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      #1;
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang("rvalid");
    check("rdata", d, {24'h000000, ed});
    check("rresp", r, er);
  endtask
  // ==========================================================
  // pixel and sync drivers
  // new pixel goes in at the edge after a tick so the next tick takes it
  task automatic send_pix(input osbt_pix_t v);
    int n;
    #1;
    for (n = 0; n < 8 && pixelTick !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    pixIn <= v;
    #1;
  endtask
  // pin rise to delayed pulse, in cycles; hsync field clamps above 63
  task automatic meas(input logic h, input logic [7:0] d);
    int n, e, got;
    axi_wr(h ? A_HALF : A_HS, d, RESP_OKAY);
    e = (h || d[6:0] < 7'h40) ? int'(d[6:0]) : 63;
    @(posedge clk_sys);
    if (h) halfLineIn <= 1'b1;
    else hsyncIn <= 1'b1;
    got = -1;
    for (n = 1; n < 7000 && got < 0; n++) begin
      @(posedge clk_sys);
      #1;
      if ((h ? halfLinePulse : hsyncDelayed) === 1'b1) got = n;
    end
    if (got < 0) hang("delayed pulse");
    check("delay window", got >= 48 * e + (e ? 0 : 3) && got <= 48 * e + 6, 1);
    @(posedge clk_sys);
    hsyncIn <= 1'b0;
    halfLineIn <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [17:0] regA [3];
    logic [7:0] v;
    logic [2:0] sel;
    logic [2:0] rgbSeen;
    logic cc;
    osbt_pix_t p;
    int i, n;
    regA = '{A_HS, A_HALF, A_CFG};
    void'($urandom(61));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 3; i++) axi_rd(regA[i], REG_RST, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      v = 8'($urandom);
      if (i == 2) v[3:0] = 4'h0;
      axi_wr(regA[i], v, RESP_OKAY);
      axi_rd(regA[i], v, RESP_OKAY);
    end
    s_axi_wstrb <= 4'hE;
    axi_wr(A_CFG, {~v[7:4], 4'h0}, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(A_CFG, v, RESP_OKAY);
    axi_wr(A_NONE, 8'hFF, RESP_SLVERR);
    axi_rd(A_NONE, 8'h00, RESP_SLVERR);
    $display("test registers done");
    // every select code, then random ones, each with one lit pixel
    for (i = 0; i < 11; i++) begin
      sel = (i < 8) ? 3'(i) : 3'($urandom);
      cc = (i < 2) ? ~i[0] : 1'($urandom);
      axi_wr(A_CFG, {cc, sel, 4'h0}, RESP_OKAY);
      check("caption mode", captionModeSelect, cc);
      p = '0;
      repeat (4) send_pix(p);
      p.rgb = 3'($urandom_range(1, 7));
      p.blankReq = 1'b1;
      p.underline = (i < 2) ? 1'b1 : 1'($urandom);
      p.serialAttr = (i < 2) ? 1'b1 : 1'($urandom);
      send_pix(p);
      rgbSeen = 3'h0;
      for (n = 0; n < 12 && litHist[3] !== 1'b1; n++) begin
        send_pix('0);
        if (rgbOut !== 3'h0) rgbSeen = rgbOut;
      end
      check("lit pixel", litHist, 8'h08);
      check("rgb", rgbSeen, p.rgb);
      check("fast blanking", fblHist, fbl_exp(sel));
      check("underline", ulHist[3], p.underline & ~(cc & p.serialAttr));
    end
    $display("test blanking done");
    for (i = 0; i < 5; i++) meas(1'b0, i == 0 ? 8'h00 : i == 1 ? 8'h01 : i == 2 ? 8'h3F :
      i == 3 ? 8'hC5 : 8'($urandom));
    $display("test hsync delay done");
    for (i = 0; i < 4; i++) meas(1'b1, i == 0 ? 8'h00 : i == 1 ? 8'h7F : i == 2 ? 8'h81 :
      8'($urandom));
    $display("test half line delay done");
    give_verdict();
  end
endmodule
